// *** design/cabe_consts.svh ***
/*
 * Constants of the execution core: flag positions, reset values,
 * register port offsets, instruction field codes and cycle counts.
 * Assumes inclusion by bare name from the core and the bench.
 */
`ifndef CABE_CONSTS_SVH
`define CABE_CONSTS_SVH

// Flag register bit positions
`define CABE_FLG_C 3'd0
`define CABE_FLG_Z 3'd1
`define CABE_FLG_N 3'd2
`define CABE_FLG_V 3'd3
`define CABE_FLG_S 3'd4
`define CABE_FLG_H 3'd5
`define CABE_FLG_T 3'd6
`define CABE_FLG_I 3'd7

`define CABE_FLAGS_RST 8'h00
`define CABE_CTRL_RST  8'h00
`define CABE_CTRL_RUN  0

// Register port offsets; 8'h00..8'h1F are the general registers
`define CABE_RA_FLAGS 8'h20
`define CABE_RA_PCL   8'h21
`define CABE_RA_PCH   8'h22
`define CABE_RA_CTRL  8'h23
`define CABE_RA_STAT  8'h24

// Major opcode, instruction bits 15:12
`define CABE_MJ_REGA  4'h0
`define CABE_MJ_SUBK  4'h1
`define CABE_MJ_SBCK  4'h2
`define CABE_MJ_ANDK  4'h3
`define CABE_MJ_ORK   4'h4
`define CABE_MJ_MASK  4'h5
`define CABE_MJ_CMPK  4'h6
`define CABE_MJ_WORD  4'h7
`define CABE_MJ_RELATIVE_JUMP  4'h8
`define CABE_MJ_RELATIVE_SUBROUTINE_ENTRY 4'h9
`define CABE_MJ_BRCH  4'hA
`define CABE_MJ_SKIP  4'hB
`define CABE_MJ_IOBIT 4'hC
`define CABE_MJ_LOGIC 4'hD
`define CABE_MJ_MISC  4'hE
`define CABE_MJ_CTRL  4'hF

// Control sub-opcode, instruction bits 11:8
`define CABE_CT_PJMP  4'h0
`define CABE_CT_PCALL 4'h1
`define CABE_CT_AJMP  4'h2
`define CABE_CT_ACALL 4'h3
`define CABE_CT_RET   4'h4
`define CABE_CT_INTERRUPT_EXIT  4'h5

// Total cycles per instruction
`define CABE_CYC_WORD  2'd2
`define CABE_CYC_MUL   2'd2
`define CABE_CYC_RELATIVE_JUMP  2'd2
`define CABE_CYC_RELATIVE_SUBROUTINE_ENTRY 2'd3
`define CABE_CYC_PJMP  2'd2
`define CABE_CYC_PCALL 2'd3
`define CABE_CYC_AJMP  3'd3
`define CABE_CYC_ACALL 3'd4
`define CABE_CYC_RET   3'd4
`define CABE_CYC_BRT   2'd2

`define CABE_ZPTR_LO 5'd30
`define CABE_STK_DEPTH 8

`endif

// *** design/cabe_core.sv ***
/*
 * Execution core for arithmetic, logic, multiply, branch and skip
 * instructions, with register file, flag register and return stack.
 * Assumes program memory and I/O space answer in the same cycle as
 * the address they are given, all on CORE_CLK_IN.
 */
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cabe_consts.svh"

// What this block does
// - Add registers, optionally with carry, in one cycle; flags Z C N V H.
// - Word immediate add or subtract on a pair in two cycles; Z C N V S.
// - Subtract register or constant, optionally borrow, one cycle; Z C N V H.
// - AND, OR, XOR in one cycle; only Z N V change, carry kept.
// - Mask clear ANDs with complemented constant in one cycle; Z N V.
// - Test ANDs a register with itself in one cycle; Z N V.
// - Multiplies put the 16-bit product in R1:R0 in two cycles; Z C.
// - Fractional multiplies shift the product left once; two cycles; Z C.
// - Relative call loads PC plus offset plus one in three, jump in two.
// - Pointer jump loads PC from Z in two cycles, pointer call in three.
// - Absolute jump three cycles, absolute call four, both returns four.
// - Equal compare skips the next instruction; one to three cycles.
// - Compares set Z N V C H without storing, in one cycle.
// - Register bit tests skip on clear or set bit.
// - I/O bit tests skip on clear or set bit.
// - Flag branch loads PC plus offset plus one; one or two cycles.
// - Signed branches decide on N xor V.
// - Unsigned same-or-higher and lower branches test the carry.
// - Branches exist on H, T, V and I flags, set and clear forms.
// - I/O bit set or clear rewrites the whole register read.
// - I/O bit set or clear reaches only I/O addresses 0 to 31.
module cabe_core (
	input  wire logic                    CORE_CLK_IN,   // Core clock
	input  wire logic                    RST_N_IN,      // Sync reset, low
	output logic [15:0]                  PM_ADDR_OUT,   // Program address
	input  wire logic [15:0]             PM_DATA_IN,    // Instruction word
	output cabe_pkg::cabe_io_req_t       IO_REQ_OUT,    // I/O request
	input  wire logic [7:0]              IO_RDATA_IN,   // I/O read data
	input  wire cabe_pkg::cabe_reg_req_t REG_REQ_IN,    // Register port
	output logic [7:0]                   REG_RDATA_OUT  // Register read
);
	import cabe_pkg::*;

	logic [7:0]   gpr [0:31];
	logic [15:0]  stk [0:`CABE_STK_DEPTH-1];
	logic [15:0]  pc_q, pc_d, iw_q, g16_v, push_v;
	logic [7:0]   flags_q, flags_d, ctrl_q, ctrl_d, rdat_q, g8_v;
	logic [7:0]   ar_fl, lg_fl, wd_fl, pr_fl;
	logic [1:0]   wait_q, wait_d;
	logic [2:0]   sp_q, sp_d;
	logic         gw8, gw16, push;
	logic [4:0]   g16_i;
	cabe_state_t  st_q, st_d;
	cabe_io_req_t io_q, io_d;

	function automatic logic two_word(input logic [15:0] w);
		two_word = (w[15:12] == `CABE_MJ_CTRL) &&
			(w[11:8] == `CABE_CT_AJMP || w[11:8] == `CABE_CT_ACALL);
	endfunction : two_word

	// Field decode
	wire [15:0] iw       = PM_DATA_IN;
	wire [3:0]  maj      = iw[15:12];
	wire [1:0]  sub2     = iw[11:10];
	wire        run      = ctrl_q[`CABE_CTRL_RUN];
	wire        imm_form = (maj >= `CABE_MJ_SUBK) && (maj <= `CABE_MJ_CMPK);
	wire [4:0]  dsel     = imm_form ? {1'b1, iw[11:8]} : iw[9:5];
	wire [7:0]  opa      = gpr[dsel];
	wire [7:0]  opb      = imm_form ? iw[7:0] : gpr[iw[4:0]];
	wire        is_sub   = (maj == `CABE_MJ_REGA && sub2[1]) ||
		maj == `CABE_MJ_SUBK || maj == `CABE_MJ_SBCK ||
		maj == `CABE_MJ_CMPK || (maj == `CABE_MJ_LOGIC && sub2 == 2'b11) ||
		(maj == `CABE_MJ_MISC && sub2 == 2'b00);
	wire        use_c    = (maj == `CABE_MJ_REGA && sub2[0]) ||
		maj == `CABE_MJ_SBCK || (maj == `CABE_MJ_MISC && sub2 == 2'b00);
	wire        cin      = use_c & flags_q[`CABE_FLG_C];

	// Byte adder and subtracter
	wire [8:0] ar9 = is_sub ? {1'b0, opa} - {1'b0, opb} - {8'h00, cin}
		: {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
	wire [4:0] ar5 = is_sub ? {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin}
		: {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	wire [7:0] ar_r = ar9[7:0];
	wire       ar_v = is_sub
		? (opa[7] & ~opb[7] & ~ar_r[7]) | (~opa[7] & opb[7] & ar_r[7])
		: (opa[7] & opb[7] & ~ar_r[7]) | (~opa[7] & ~opb[7] & ar_r[7]);
	// Borrow forms keep Z only while the whole chain stays zero
	wire       ar_z = (ar_r == 8'h00) &
		(~(use_c & is_sub) | flags_q[`CABE_FLG_Z]);

	// Logic unit
	wire       tst  = (maj == `CABE_MJ_MISC) && (sub2 == 2'b10);
	wire [7:0] lg_r = (maj == `CABE_MJ_ORK ||
		(maj == `CABE_MJ_LOGIC && sub2 == 2'b01)) ? opa | opb
		: (maj == `CABE_MJ_LOGIC && sub2 == 2'b10) ? opa ^ opb
		: (maj == `CABE_MJ_MASK) ? opa & ~opb
		: opa & (tst ? opa : opb);

	// Word immediate unit on pairs 24..31
	wire [4:0]  wi  = {2'b11, iw[7:6], 1'b0};
	wire [15:0] wv  = {gpr[{wi[4:1], 1'b1}], gpr[wi]};
	wire [16:0] w17 = iw[8] ? {1'b0, wv} - {11'h000, iw[5:0]}
		: {1'b0, wv} + {11'h000, iw[5:0]};
	wire [15:0] wr16 = w17[15:0];
	wire        wd_v = iw[8] ? (wv[15] & ~wr16[15]) : (~wv[15] & wr16[15]);

	// Multiplier on registers 16..23
	wire [2:0]  pk   = iw[9:7];
	wire [7:0]  pa   = gpr[{2'b10, iw[6:4]}];
	wire [7:0]  pb   = gpr[{2'b10, iw[3:1]}];
	wire        a_s  = pk == 3'd1 || pk == 3'd2 || pk == 3'd4 || pk == 3'd5;
	wire        b_s  = pk == 3'd1 || pk == 3'd4;
	wire        frac = pk >= 3'd3;
	wire [15:0] pae  = {{8{a_s & pa[7]}}, pa};
	wire [15:0] pbe  = {{8{b_s & pb[7]}}, pb};
	wire [15:0] praw = pae * pbe;
	wire [15:0] pout = frac ? {praw[14:0], 1'b0} : praw;

	// Branch and skip decisions
	wire [2:0]  bsel = iw[10:8];
	wire        fbit = (bsel == `CABE_FLG_S)
		? flags_q[`CABE_FLG_N] ^ flags_q[`CABE_FLG_V] : flags_q[bsel];
	wire        take = fbit == iw[11];
	wire [7:0]  flag_register = gpr[iw[7:3]];
	wire        rbit = flag_register[iw[2:0]];
	wire        iobit = IO_RDATA_IN[iw_q[2:0]];
	wire [7:0]  bmask = 8'h01 << iw_q[2:0];
	wire [15:0] pc1  = pc_q + 16'h0001;
	wire [15:0] rel12 = pc1 + {{4{iw[11]}}, iw[11:0]};
	wire [15:0] rel8 = pc1 + {{8{iw[7]}}, iw[7:0]};
	wire [15:0] zptr = {gpr[`CABE_ZPTR_LO + 5'd1], gpr[`CABE_ZPTR_LO]};
	wire [2:0]  sp_m1 = sp_q - 3'd1;

	// Register port decode
	wire        sw_gpr = REG_REQ_IN.wr && REG_REQ_IN.addr < 8'h20;
	wire [7:0]  stat = {6'h00, ~run, (st_q != ST_EXEC) || (wait_q != 2'd0)};
	wire [7:0]  rdat_d = !REG_REQ_IN.rd ? rdat_q
		: REG_REQ_IN.addr < 8'h20 ? gpr[REG_REQ_IN.addr[4:0]]
		: REG_REQ_IN.addr == `CABE_RA_FLAGS ? flags_q
		: REG_REQ_IN.addr == `CABE_RA_PCL ? pc_q[7:0]
		: REG_REQ_IN.addr == `CABE_RA_PCH ? pc_q[15:8]
		: REG_REQ_IN.addr == `CABE_RA_CTRL ? ctrl_q
		: REG_REQ_IN.addr == `CABE_RA_STAT ? stat : 8'h00;
	assign ctrl_d = (REG_REQ_IN.wr && REG_REQ_IN.addr == `CABE_RA_CTRL)
		? REG_REQ_IN.wdata : ctrl_q;

	// Flag vectors per instruction class
	always_comb begin
		ar_fl = flags_q;
		ar_fl[`CABE_FLG_C] = ar9[8];
		ar_fl[`CABE_FLG_Z] = ar_z;
		ar_fl[`CABE_FLG_N] = ar_r[7];
		ar_fl[`CABE_FLG_V] = ar_v;
		ar_fl[`CABE_FLG_H] = ar5[4];
		lg_fl = flags_q;
		lg_fl[`CABE_FLG_Z] = lg_r == 8'h00;
		lg_fl[`CABE_FLG_N] = lg_r[7];
		lg_fl[`CABE_FLG_V] = 1'b0;
		wd_fl = flags_q;
		wd_fl[`CABE_FLG_C] = w17[16];
		wd_fl[`CABE_FLG_Z] = wr16 == 16'h0000;
		wd_fl[`CABE_FLG_N] = wr16[15];
		wd_fl[`CABE_FLG_V] = wd_v;
		wd_fl[`CABE_FLG_S] = wr16[15] ^ wd_v;
		pr_fl = flags_q;
		pr_fl[`CABE_FLG_C] = praw[15];
		pr_fl[`CABE_FLG_Z] = pout == 16'h0000;
	end

	// Sequencer
	always_comb begin
		pc_d = pc_q;
		st_d = st_q;
		sp_d = sp_q;
		io_d = '0;
		wait_d = (wait_q != 2'd0) ? wait_q - 2'd1 : 2'd0;
		flags_d = (REG_REQ_IN.wr && REG_REQ_IN.addr == `CABE_RA_FLAGS)
			? REG_REQ_IN.wdata : flags_q;
		gw8 = 1'b0;
		g8_v = ar_r;
		gw16 = 1'b0;
		g16_i = wi;
		g16_v = wr16;
		push = 1'b0;
		push_v = pc1;
		if (wait_q == 2'd0) begin
			unique case (st_q)
			ST_EXEC: if (run) begin
				pc_d = pc1;
				case (maj)
				`CABE_MJ_REGA, `CABE_MJ_SUBK, `CABE_MJ_SBCK: begin
					gw8 = 1'b1;
					flags_d = ar_fl;
				end
				`CABE_MJ_CMPK: flags_d = ar_fl;
				`CABE_MJ_ANDK, `CABE_MJ_ORK, `CABE_MJ_MASK: begin
					gw8 = 1'b1;
					g8_v = lg_r;
					flags_d = lg_fl;
				end
				`CABE_MJ_WORD: begin
					gw16 = 1'b1;
					flags_d = wd_fl;
					wait_d = `CABE_CYC_WORD - 2'd1;
				end
				`CABE_MJ_RELATIVE_JUMP: begin
					pc_d = rel12;
					wait_d = `CABE_CYC_RELATIVE_JUMP - 2'd1;
				end
				`CABE_MJ_RELATIVE_SUBROUTINE_ENTRY: begin
					push = 1'b1;
					sp_d = sp_q + 3'd1;
					pc_d = rel12;
					wait_d = `CABE_CYC_RELATIVE_SUBROUTINE_ENTRY - 2'd1;
				end
				`CABE_MJ_BRCH: if (take) begin
					pc_d = rel8;
					wait_d = `CABE_CYC_BRT - 2'd1;
				end
				`CABE_MJ_SKIP: begin
					if (sub2[1]) begin
						io_d.rd = 1'b1;
						io_d.addr = {1'b0, iw[7:3]};
						pc_d = pc_q;
						st_d = ST_IOSKIP;
					end else if (rbit == sub2[0]) begin
						st_d = ST_SKIP;
					end
				end
				`CABE_MJ_IOBIT: begin
					io_d.rd = 1'b1;
					io_d.addr = {1'b0, iw[7:3]};
					pc_d = pc_q;
					st_d = ST_IOSET;
				end
				`CABE_MJ_LOGIC: begin
					flags_d = (sub2 == 2'b11) ? ar_fl : lg_fl;
					gw8 = sub2 != 2'b11;
					g8_v = lg_r;
				end
				`CABE_MJ_MISC: begin
					unique case (sub2)
					2'b00: flags_d = ar_fl;
					2'b01: if (opa == opb) st_d = ST_SKIP;
					2'b10: flags_d = lg_fl;
					2'b11: begin
						gw16 = 1'b1;
						g16_i = 5'd0;
						g16_v = pout;
						flags_d = pr_fl;
						wait_d = `CABE_CYC_MUL - 2'd1;
					end
					endcase
				end
				`CABE_MJ_CTRL: begin
					case (iw[11:8])
					`CABE_CT_PJMP: begin
						pc_d = zptr;
						wait_d = `CABE_CYC_PJMP - 2'd1;
					end
					`CABE_CT_PCALL: begin
						push = 1'b1;
						sp_d = sp_q + 3'd1;
						pc_d = zptr;
						wait_d = `CABE_CYC_PCALL - 2'd1;
					end
					`CABE_CT_AJMP: st_d = ST_JMP2;
					`CABE_CT_ACALL: st_d = ST_CALL2;
					`CABE_CT_RET, `CABE_CT_INTERRUPT_EXIT: begin
						sp_d = sp_m1;
						pc_d = stk[sp_m1];
						wait_d = 2'(`CABE_CYC_RET - 3'd1);
						if (iw[8])
							flags_d[`CABE_FLG_I] = 1'b1;
					end
					default: pc_d = pc1;
					endcase
				end
				default: pc_d = pc1;
				endcase
			end
			ST_JMP2: begin
				pc_d = iw;
				wait_d = 2'(`CABE_CYC_AJMP - 3'd2);
				st_d = ST_EXEC;
			end
			ST_CALL2: begin
				push = 1'b1;
				sp_d = sp_q + 3'd1;
				pc_d = iw;
				wait_d = 2'(`CABE_CYC_ACALL - 3'd2);
				st_d = ST_EXEC;
			end
			ST_SKIP: begin
				pc_d = two_word(iw) ? pc_q + 16'h0002 : pc1;
				wait_d = two_word(iw) ? 2'd1 : 2'd0;
				st_d = ST_EXEC;
			end
			ST_IOSET: begin
				io_d.wr = 1'b1;
				io_d.addr = {1'b0, iw_q[7:3]};
				io_d.wdata = iw_q[8] ? IO_RDATA_IN | bmask
					: IO_RDATA_IN & ~bmask;
				pc_d = pc1;
				st_d = ST_EXEC;
			end
			ST_IOSKIP: begin
				pc_d = pc1;
				st_d = (iobit == iw_q[10]) ? ST_SKIP : ST_EXEC;
			end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			pc_q <= 16'h0000;
			iw_q <= 16'h0000;
			st_q <= ST_EXEC;
			wait_q <= 2'd0;
			sp_q <= 3'd0;
			flags_q <= `CABE_FLAGS_RST;
			ctrl_q <= `CABE_CTRL_RST;
			io_q <= '0;
			rdat_q <= 8'h00;
		end else begin
			pc_q <= pc_d;
			iw_q <= (st_q == ST_EXEC) ? iw : iw_q;
			st_q <= st_d;
			wait_q <= wait_d;
			sp_q <= sp_d;
			flags_q <= flags_d;
			ctrl_q <= ctrl_d;
			io_q <= io_d;
			rdat_q <= rdat_d;
		end
	end

	// Register file and return stack; core writes win over software
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			for (int i = 0; i < 32; i++)
				gpr[i] <= 8'h00;
		end else begin
			if (sw_gpr)
				gpr[REG_REQ_IN.addr[4:0]] <= REG_REQ_IN.wdata;
			if (gw8)
				gpr[dsel] <= g8_v;
			if (gw16) begin
				gpr[g16_i] <= g16_v[7:0];
				gpr[{g16_i[4:1], 1'b1}] <= g16_v[15:8];
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (push)
			stk[sp_q] <= push_v;
	end

	assign PM_ADDR_OUT = pc_q;
	assign IO_REQ_OUT = io_q;
	assign REG_RDATA_OUT = rdat_q;
endmodule : cabe_core
`default_nettype wire

// *** design/cabe_pkg.sv ***
/*
 * Types of the execution core: sequencer states and the request
 * carriers of the register port and the I/O port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cabe_pkg;
	typedef enum logic [2:0] {
		ST_EXEC,
		ST_JMP2,
		ST_CALL2,
		ST_SKIP,
		ST_IOSET,
		ST_IOSKIP
	} cabe_state_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cabe_io_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cabe_reg_req_t;
endpackage : cabe_pkg

// *** testbench/cabe_chk.sv ***
/* Port checker of the execution core.
 * Assumes binding to cabe_core and one clock. */
`timescale 1ns/1ns
`default_nettype none
`include "cabe_consts.svh"
module cabe_chk (
	input wire logic                    CORE_CLK_IN,  // Clock
	input wire logic                    RST_N_IN,     // Reset
	input wire logic [15:0]             PM_ADDR_OUT,  // Program address
	input wire logic [15:0]             PM_DATA_IN,   // Instruction
	input wire cabe_pkg::cabe_io_req_t  IO_REQ_OUT,   // I/O request
	input wire logic [7:0]              IO_RDATA_IN,  // I/O data
	input wire cabe_pkg::cabe_reg_req_t REG_REQ_IN,   // Register port
	input wire logic [7:0]              REG_RDATA_OUT // Read data
);
	import cabe_pkg::*;
	logic       run_q;
	wire        ctl_wr = REG_REQ_IN.wr && REG_REQ_IN.addr == `CABE_RA_CTRL;
	wire [7:0]  pc_lo = PM_ADDR_OUT[7:0];
	wire [15:0] rj_tgt = PM_ADDR_OUT + 16'h0001 +
		{{4{PM_DATA_IN[11]}}, PM_DATA_IN[11:0]};
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN)
			run_q <= 1'b0;
		else if (ctl_wr)
			run_q <= REG_REQ_IN.wdata[0];
	end
	io_wr_pair_a: assert property (IO_REQ_OUT.wr |-> $past(IO_REQ_OUT.rd)
		&& $past(IO_REQ_OUT.addr) == IO_REQ_OUT.addr)
		else $error("I/O write without read before it");
	io_one_bit_a: assert property (
		IO_REQ_OUT.wr |-> $countones(IO_REQ_OUT.wdata ^ $past(IO_RDATA_IN)) <= 1)
		else $error("I/O bit write changed more than one bit");
	io_low_addr_a: assert property (
		IO_REQ_OUT.wr |-> IO_REQ_OUT.addr <= 6'h1F)
		else $error("I/O bit write above low range");
	halt_still_a: assert property (!run_q && !ctl_wr |=>
		$stable(PM_ADDR_OUT) && !IO_REQ_OUT.rd)
		else $error("core moved while halted");
	rd_hold_a: assert property (!REG_REQ_IN.rd |=> $stable(REG_RDATA_OUT))
		else $error("read data changed without read");
	unmapped_zero_a: assert property (REG_REQ_IN.rd &&
		REG_REQ_IN.addr > `CABE_RA_STAT |=> REG_RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	pc_read_a: assert property (!run_q && REG_REQ_IN.rd &&
		REG_REQ_IN.addr == `CABE_RA_PCL |=> REG_RDATA_OUT == $past(pc_lo))
		else $error("program counter low read wrong");
	jump_target_a: assert property (
		!run_q && ctl_wr && REG_REQ_IN.wdata[0] ##1
		PM_DATA_IN[15:12] == `CABE_MJ_RELATIVE_JUMP |=>
		PM_ADDR_OUT == $past(rj_tgt) ##1 $stable(PM_ADDR_OUT))
		else $error("relative jump target or time wrong");
endmodule : cabe_chk
bind cabe_core cabe_chk u_chk (.CORE_CLK_IN(CORE_CLK_IN),
	.RST_N_IN(RST_N_IN), .PM_ADDR_OUT(PM_ADDR_OUT),
	.PM_DATA_IN(PM_DATA_IN), .IO_REQ_OUT(IO_REQ_OUT),
	.IO_RDATA_IN(IO_RDATA_IN), .REG_REQ_IN(REG_REQ_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT));
`default_nettype wire

// *** testbench/cabe_mem_mdl.sv ***
/* Program memory and I/O space model.
 * Assumes the bench loads rom and io. */
`timescale 1ns/1ns
`default_nettype none
module cabe_mem_mdl #(
	parameter logic [7:0] W1C_MASK = 8'h80
) (
	input  wire logic                   clk_in,      // Core clock
	input  wire logic [15:0]            pm_addr_in,  // Program address
	output logic [15:0]                 pm_data_out, // Instruction
	input  wire cabe_pkg::cabe_io_req_t io_req_in,   // I/O request
	output logic [7:0]                  io_rdata_out // I/O data
);
	import cabe_pkg::*;
	logic [15:0] rom [0:255];
	logic [7:0]  io [0:63];
	logic [7:0]  last_q = 8'h00;
	logic [7:0]  wr_seen;
	wire [7:0]   cur = io[io_req_in.addr];
	assign pm_data_out = rom[pm_addr_in[7:0]];
	// Idle bus shows inverse of last value
	assign io_rdata_out = io_req_in.rd ? cur : ~last_q;
	always @(posedge clk_in) begin
		if (io_req_in.rd)
			last_q <= cur;
		if (io_req_in.wr) begin
			wr_seen <= io_req_in.wdata;
			io[io_req_in.addr] <= (io_req_in.wdata & ~W1C_MASK) |
				(cur & W1C_MASK & ~io_req_in.wdata);
		end
	end
endmodule : cabe_mem_mdl
`default_nettype wire

// *** testbench/testbench.sv ***
/* Self-checking bench of the execution core.
 * Assumes the checker binds itself. */
`timescale 1ns/1ns
`default_nettype none
`include "cabe_consts.svh"
module testbench;
	import cabe_pkg::*;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic [15:0]   pm_addr;
	logic [15:0]   pm_data;
	cabe_io_req_t  io_req;
	logic [7:0]    io_rdata;
	cabe_reg_req_t rq = '0;
	logic [7:0]    rdata;
	logic [15:0]   tr [0:15];
	int            num_errors = 0;
	int            checked = 0;
	logic [7:0]    ra, va, rb, vb, fp, dd, ed, ef, cy, z, t;
	logic [15:0]   w, w1;
	logic          tk;
	logic [87:0]   alu [9] = '{
		88'h01_7F_02_01_00_0022_01_80_2C_01, 88'h03_80_04_80_01_D064_03_80_05_01,
		88'h10_10_10_10_00_1011_10_FF_25_01, 88'h11_FF_11_FF_00_510F_11_F0_04_01,
		88'h03_05_04_05_01_DC64_03_05_02_01, 88'h05_80_05_80_0A_E8A0_05_80_04_01,
		88'h12_FF_13_FF_02_EC26_01_FE_01_02, 88'h12_80_13_80_03_EDA6_01_80_00_02,
		88'h18_FF_19_7F_03_7001_19_80_0C_02};
	logic [55:0]   flow [10] = '{
		56'h8005_F600_00_06_02, 56'h9005_F600_00_06_03, 56'hF000_F600_10_10_02,
		56'hF100_F600_10_10_03, 56'hF200_0020_00_20_03, 56'hF300_0020_00_20_04,
		56'hB428_F200_01_03_03, 56'hE4C7_F600_00_02_02, 56'hB420_F600_00_01_01,
		56'hBC13_F600_00_02_03};
	always #5 clk = ~clk;
	cabe_core uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PM_ADDR_OUT(pm_addr),
		.PM_DATA_IN(pm_data), .IO_REQ_OUT(io_req), .IO_RDATA_IN(io_rdata),
		.REG_REQ_IN(rq), .REG_RDATA_OUT(rdata));
	cabe_mem_mdl mdl (.clk_in(clk), .pm_addr_in(pm_addr),
		.pm_data_out(pm_data), .io_req_in(io_req), .io_rdata_out(io_rdata));
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		rq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		rq <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, exp, input string nm);
		rq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		rq <= '0;
		#1 chk(nm, {8'h00, rdata}, {8'h00, exp});
		@(posedge clk);
	endtask : rd
	task automatic ld(input logic [15:0] a0, a1);
		for (int i = 0; i < 256; i++)
			mdl.rom[i] = 16'hF600;
		mdl.rom[0] = a0;
		mdl.rom[1] = a1;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : ld
	task automatic go(input int n);
		wr(`CABE_RA_CTRL, 8'h01);
		for (int i = 0; i < n; i++) begin
			#1 tr[i] = pm_addr;
			@(posedge clk);
		end
	endtask : go
	task automatic fl(input logic [7:0] c, d);
		chk("pc at end", tr[c - 1], {8'h00, d});
		chk("pc after", tr[c], {8'h00, d} + 16'h0001);
	endtask : fl
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
	initial begin
		mdl.io[2] = 8'h08;
		mdl.io[4] = 8'h82;
		ld(16'hF600, 16'hF600);
		rd(`CABE_RA_CTRL, 8'h00, "ctrl");
		wr(`CABE_RA_PCL, 8'h55);
		rd(`CABE_RA_PCL, 8'h00, "pc low");
		rd(8'h30, 8'h00, "unmapped");
		rd(`CABE_RA_STAT, 8'h02, "status");
		$display("map test done");
		foreach (alu[i]) begin
			{ra, va, rb, vb, fp, w, dd, ed, ef, cy} = alu[i];
			ld(w, 16'hF600);
			wr(ra, va);
			wr(rb, vb);
			wr(`CABE_RA_FLAGS, fp);
			go(cy + 1);
			fl(cy, 8'h01);
			rd(dd, ed, "result");
			rd(`CABE_RA_FLAGS, ef, "flags");
		end
		$display("alu test done");
		foreach (flow[i]) begin
			{w, w1, z, t, cy} = flow[i];
			ld(w, w1);
			wr(8'h1E, z);
			wr(8'h05, z);
			go(cy + 1);
			fl(cy, t);
		end
		ld(16'h9005, 16'hF600);
		mdl.rom[6] = 16'hF500;
		go(8);
		fl(7, 8'h01);
		rd(`CABE_RA_FLAGS, 8'h80, "flags");
		$display("flow test done");
		for (int f = 0; f < 8; f++)
			for (int s = 0; s < 2; s++)
				for (int p = 0; p < 2; p++) begin
					ld(16'hA002 | (s << 11) | (f << 8), 16'hF600);
					fp = p ? (f == 4 ? 8'h04 : 8'h01 << f) : 8'h00;
					wr(`CABE_RA_FLAGS, fp);
					tk = (p == s);
					go(3);
					fl(tk ? 8'h02 : 8'h01, tk ? 8'h03 : 8'h01);
				end
		$display("branch test done");
		ld(16'hC120, 16'hF600);
		go(3);
		chk("pc", tr[2], 16'h0002);
		chk("io write", {8'h00, mdl.wr_seen}, 16'h0083);
		chk("io reg", {8'h00, mdl.io[4]}, 16'h0003);
		$display("io test done");
		test_done();
	end
endmodule : testbench
`default_nettype wire
